/* File: scp_host_model.sv */
// bus host model: start, stop and byte transfers
`timescale 1ns/10ps
module scp_host_model
(
  input  wire logic clk,
  input  wire logic sdaLine,
  output      logic sclPull,
  output      logic sdaPull
);
  initial {sclPull, sdaPull} = 2'b00;
  task automatic wt(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic cond(input logic endPull);
    sclPull = 1'b1;
    wt(2);
    sdaPull = !endPull;
    wt(2);
    sclPull = 1'b0;
    wt(4);
    sdaPull = endPull;
    wt(4);
  endtask
  // data set mid low phase, so no edge looks like a start
  task automatic bit_io(input logic b, output logic seen);
    sclPull = 1'b1;
    wt(2);
    sdaPull = !b;
    wt(2);
    sclPull = 1'b0;
    wt(4);
    seen = sdaLine;
  endtask
  task automatic xfer(input logic [7:0] tx, input logic ackOut,
                      output logic [7:0] rx, output logic ackIn);
    for (int i = 7; i >= 0; i--)
      bit_io(tx[i], rx[i]);
    bit_io(ackOut, ackIn);
  endtask
endmodule

/* File: scp_pkg.sv */
// types of the serial configuration slave port
package scp_pkg;
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ADDR,
    ST_ADDR_ACK,
    ST_WRITE,
    ST_WRITE_ACK,
    ST_READ,
    ST_READ_ACK
  } scp_state_t;

  typedef struct packed {
    logic       valid;
    logic [7:0] offset;
    logic [7:0] data;
  } scp_wr_t;
endpackage

/* File: scp_port_properties.sv */
// concurrent checks on the slave port pins
`timescale 1ns/10ps
module scp_port_properties
  import scp_pkg::*;
(
  input wire logic             ref_clk,
  input wire logic             resetn,
  input wire logic             sclIn,
  input wire logic             sdaOut,
  input wire logic             sdaOe,
  input wire logic             second_port_addr_enable,
  input wire logic             portSel,
  input wire scp_pkg::scp_wr_t wrEvent,
  input wire logic             proxySclIn,
  input wire logic             proxySclOut,
  input wire logic             proxySclOe
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  // ----------------------------------------
  // checks
  // ----------------------------------------
  // released proxy line held low by a remote slave
  sequence s_stretch;
    (!proxySclOe && !proxySclIn) [*4];
  endsequence
  sequence s_ack_low;
    sdaOe [*6];
  endsequence
  chk_sda_low_only:
  assert property (sdaOe |-> !sdaOut) else $error("data pin driven high");
  chk_proxy_low_only:
  assert property (proxySclOe |-> !proxySclOut) else $error("proxy clock driven high");
  chk_ack_holds:
  assert property ($rose(sdaOe) |-> s_ack_low) else $error("data pull too short");
  chk_data_scl_low:
  assert property ($changed(sdaOe) |-> !$past(sclIn)) else $error("data moved with clock high");
  chk_wr_pulse:
  assert property (wrEvent.valid |=> !wrEvent.valid) else $error("write strobe too long");
  chk_wr_acked:
  assert property (wrEvent.valid |-> ##[0:1] sdaOe) else $error("stored byte not acked");
  chk_port_sel:
  assert property ($rose(portSel) |-> second_port_addr_enable) else $error("port select unasked");
  chk_proxy_half:
  assert property ($rose(proxySclOe) |-> ##[24:26] $fell(proxySclOe)) else $error("proxy half off");
  chk_stretch_wait:
  assert property (s_stretch |=> !proxySclOe) else $error("proxy ran during stretch");
endmodule

/* File: scp_regs.svh */
// constants of the serial configuration slave port
`ifndef SCP_REGS_SVH
`define SCP_REGS_SVH
`define SCP_STRAP_BASE     7'h0c
`define SCP_STRAP_LEVELS   8
`define SCP_REG_COUNT      8
`define SCP_OFS_DEVICE_ID  8'h00
`define SCP_ID_SEL_BIT     0
`define SCP_ID_ADDR_MSB    7
`define SCP_ID_ADDR_LSB    1
`define SCP_REG_RESET      8'h00
`define SCP_BITS_PER_BYTE  4'h8
`define SCP_CLK_PERIOD_NS  50
`define SCP_PROXY_HALF_NS  1250
`define SCP_PROXY_HALF_CYC (`SCP_PROXY_HALF_NS / `SCP_CLK_PERIOD_NS)
`define SCP_STRAP_SETTLE   2'h3
`endif

/* File: scp_serial_config_slave_port.sv */
// serial configuration slave port with strapped address and proxy clock
//
// Summary of operation
// - The slave address is picked from eight values by the level on the strap pin.
// - The eight 7-bit addresses run from 0x0C to 0x1A in steps of two.
// - A rising data line while the clock is high is a stop that ends the transaction.
// - Every transaction opens with a start or repeated start and closes with a stop.
// - A matching address is acknowledged by pulling data low, a mismatch leaves it released.
// - Each received write byte is acknowledged low after its eighth bit.
// - Both lines are only pulled low or released, never driven high.
// - The clock line is input only and the data line is two-way.
// - The proxy master waits while its clock line is held low by a remote slave.
// - An id-select bit picks the strap address or bits 7:1 of register 0x00.
// - With the second-port enable set the port also answers at its address plus one.
`timescale 1ns/10ps
`include "scp_regs.svh"

module scp_serial_config_slave_port
(
  input  wire logic           ref_clk,
  input  wire logic           resetn,
  input  wire logic           ce,
  input  wire logic           sclIn,
  input  wire logic           sdaIn,
  output      logic           sdaOut,
  output      logic           sdaOe,
  input  wire logic [2:0]     addrStrapPin,
  input  wire logic           second_port_addr_enable,
  output      logic           portSel,
  output      scp_pkg::scp_wr_t wrEvent,
  input  wire logic           proxyRun,
  input  wire logic           proxySclIn,
  output      logic           proxySclOut,
  output      logic           proxySclOe
);
  import scp_pkg::*;

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  logic [1:0]  sclSync;
  logic [1:0]  sdaSync;
  logic [1:0]  pxSync;
  logic [2:0]  strapSync0;
  logic [2:0]  strapSync1;
  logic        sclPrev;
  logic        sdaPrev;

  always_ff @(posedge ref_clk)
  begin
    if (!resetn)
    begin
      sclSync    <= 2'h3;
      sdaSync    <= 2'h3;
      pxSync     <= 2'h3;
      strapSync0 <= 3'h0;
      strapSync1 <= 3'h0;
      sclPrev    <= 1'h1;
      sdaPrev    <= 1'h1;
    end
    else if (ce)
    begin
      sclSync    <= {sclSync[0], sclIn};
      sdaSync    <= {sdaSync[0], sdaIn};
      pxSync     <= {pxSync[0], proxySclIn};
      strapSync0 <= addrStrapPin;
      strapSync1 <= strapSync0;
      sclPrev    <= sclSync[1];
      sdaPrev    <= sdaSync[1];
    end
  end

  wire logic sclQ = sclSync[1];
  wire logic sdaQ = sdaSync[1];
  wire logic sclRise = sclQ & ~sclPrev;
  wire logic sclFall = ~sclQ & sclPrev;
  wire logic startSeen = sclQ & sclPrev & sdaPrev & ~sdaQ;
  wire logic stopSeen = sclQ & sclPrev & ~sdaPrev & sdaQ;

  // ----------------------------------------
  // strap capture
  // ----------------------------------------
  logic [1:0]  strapWait;
  logic        strapTaken;
  logic [6:0]  strapAddr;

  wire logic [6:0] strapDecoded = `SCP_STRAP_BASE + {3'h0, strapSync1, 1'b0};
  wire logic       strapLoad = ~strapTaken & (strapWait == `SCP_STRAP_SETTLE);

  always_ff @(posedge ref_clk)
  begin
    if (!resetn)
    begin
      strapWait  <= 2'h0;
      strapTaken <= 1'h0;
      strapAddr  <= `SCP_STRAP_BASE;
    end
    else if (ce && !strapTaken)
    begin
      strapWait <= strapWait + 2'h1;
      if (strapLoad)
      begin
        strapAddr  <= strapDecoded;
        strapTaken <= 1'h1;
      end
    end
  end

  // ----------------------------------------
  // transaction state
  // ----------------------------------------
  scp_state_t  state;
  logic [3:0]  bitCnt;
  logic [7:0]  shiftReg;
  logic [7:0]  ptr;
  logic        rw;
  logic        firstByte;
  logic        masterAck;
  logic [7:0]  regFile [`SCP_REG_COUNT];

  wire logic [6:0] ownAddr = regFile[0][`SCP_ID_SEL_BIT]
                           ? regFile[0][`SCP_ID_ADDR_MSB:`SCP_ID_ADDR_LSB] : strapAddr;
  // second port at address plus one
  wire logic       hitMain = strapTaken & (shiftReg[7:1] == ownAddr);
  wire logic       hitSecond = strapTaken & second_port_addr_enable
                             & (shiftReg[7:1] == ownAddr + 7'h1);
  wire logic       byteDone = (bitCnt == `SCP_BITS_PER_BYTE);
  wire logic       edgeOk = ce & ~startSeen & ~stopSeen & sclFall;
  wire logic       inRange = (ptr < 8'(`SCP_REG_COUNT));
  wire logic [7:0] rdByte = inRange ? regFile[ptr[2:0]] : 8'h00;
  // data bytes after the offset are stored while ptr is inside the file
  wire logic       wrHit = edgeOk & (state == ST_WRITE) & byteDone & ~firstByte;
  wire logic       loadRead = edgeOk & (((state == ST_ADDR_ACK) & rw)
                            | ((state == ST_READ_ACK) & masterAck));

  always_ff @(posedge ref_clk)
  begin
    if (!resetn)
    begin
      state     <= ST_IDLE;
      bitCnt    <= 4'h0;
      shiftReg  <= 8'h00;
      ptr       <= 8'h00;
      rw        <= 1'h0;
      firstByte <= 1'h0;
      masterAck <= 1'h0;
      sdaOe     <= 1'h0;
      portSel   <= 1'h0;
    end
    else if (ce)
    begin
      if (stopSeen)
      begin
        state <= ST_IDLE;
        sdaOe <= 1'h0;
      end
      else if (startSeen)
      begin
        state     <= ST_ADDR;
        bitCnt    <= 4'h0;
        firstByte <= 1'h1;
        sdaOe     <= 1'h0;
      end
      else if (sclRise)
      begin
        if (state == ST_ADDR || state == ST_WRITE)
        begin
          shiftReg <= {shiftReg[6:0], sdaQ};
          bitCnt   <= bitCnt + 4'h1;
        end
        // master ack low asks for more
        if (state == ST_READ_ACK)
          masterAck <= ~sdaQ;
      end
      else if (sclFall)
      begin
        case (state)
          ST_ADDR:
            if (byteDone)
            begin
              if (hitMain || hitSecond)
              begin
                sdaOe   <= 1'h1;
                rw      <= shiftReg[0];
                portSel <= hitSecond & ~hitMain;
                state   <= ST_ADDR_ACK;
              end
              else
                state <= ST_IDLE;
            end
          ST_ADDR_ACK, ST_READ_ACK:
            if (loadRead)
            begin
              // a one is sent by releasing
              sdaOe    <= ~rdByte[7];
              shiftReg <= rdByte;
              ptr      <= ptr + 8'h1;
              bitCnt   <= 4'h1;
              state    <= ST_READ;
            end
            else if (state == ST_ADDR_ACK)
            begin
              sdaOe  <= 1'h0;
              bitCnt <= 4'h0;
              state  <= ST_WRITE;
            end
            else
              state <= ST_IDLE;
          ST_WRITE:
            if (byteDone)
            begin
              sdaOe     <= 1'h1;
              firstByte <= 1'h0;
              ptr       <= firstByte ? shiftReg : ptr + 8'h1;
              state     <= ST_WRITE_ACK;
            end
          ST_WRITE_ACK:
          begin
            sdaOe  <= 1'h0;
            bitCnt <= 4'h0;
            state  <= ST_WRITE;
          end
          ST_READ:
            if (byteDone)
            begin
              sdaOe <= 1'h0;
              state <= ST_READ_ACK;
            end
            else
            begin
              sdaOe    <= ~shiftReg[6];
              shiftReg <= {shiftReg[6:0], 1'b0};
              bitCnt   <= bitCnt + 4'h1;
            end
          default:
            state <= ST_IDLE;
        endcase
      end
    end
  end

  // ----------------------------------------
  // register file
  // ----------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < `SCP_REG_COUNT; gi++)
    begin : g_reg
      wire logic hitEntry = wrHit & inRange & (ptr[2:0] == 3'(gi));
      always_ff @(posedge ref_clk)
      begin
        if (!resetn)
          regFile[gi] <= `SCP_REG_RESET;
        else if (ce && hitEntry)
          regFile[gi] <= shiftReg;
        // id register defaults to the strapped address
        else if (ce && strapLoad && gi == 0)
          regFile[gi] <= {strapDecoded, 1'b0};
      end
    end
  endgenerate

  always_ff @(posedge ref_clk)
  begin
    if (!resetn)
    begin
      wrEvent <= '0;
      sdaOut  <= 1'h0;
    end
    else if (ce)
    begin
      wrEvent.valid  <= wrHit;
      wrEvent.offset <= ptr;
      wrEvent.data   <= shiftReg;
      // data pin only ever pulls low
      sdaOut         <= 1'h0;
    end
  end

  // ----------------------------------------
  // proxy master clock
  // ----------------------------------------
  logic [5:0]  pxCnt;

  // stretch: count starts only once line reads high
  wire logic pxHeld = ~proxySclOe & ~pxSync[1];
  wire logic pxDone = (pxCnt == 6'(`SCP_PROXY_HALF_CYC - 1));

  always_ff @(posedge ref_clk)
  begin
    if (!resetn)
    begin
      pxCnt       <= 6'h0;
      proxySclOe  <= 1'h0;
      proxySclOut <= 1'h0;
    end
    else if (ce)
    begin
      proxySclOut <= 1'h0;
      if (!proxyRun)
      begin
        pxCnt      <= 6'h0;
        proxySclOe <= 1'h0;
      end
      else if (pxHeld)
        pxCnt <= 6'h0;
      else if (pxDone)
      begin
        pxCnt      <= 6'h0;
        proxySclOe <= ~proxySclOe;
      end
      else
        pxCnt <= pxCnt + 6'h1;
    end
  end
endmodule

/* File: tb_scp_serial_config_slave_port.sv */
// bench for the slave port, driven by a bus host model
`timescale 1ns/10ps
module tb_scp_serial_config_slave_port;
  import scp_pkg::*;
  logic       ref_clk = 1'b0;
  logic       resetn = 1'b0;
  logic       pe = 1'b0;
  logic       hold = 1'b0;
  logic       ce = 1'b1;
  logic       pRun = 1'b1;
  logic [2:0] strap = 3'h0;
  logic       sdaOe, sdaOut, portSel, pOe, pOut, sclPull, sdaPull, ack, a1, a2;
  logic [7:0] rd, rd2;
  scp_wr_t    wr;
  scp_wr_t    wq[$];
  int         errors = 0;
  int         total_checks = 0;
  // pull-ups on both open drain lines
  wire logic  sda = !sdaPull && !(sdaOe && !sdaOut);
  wire logic  psc = !(pOe && !pOut) && !hold;
  always #25 ref_clk = ~ref_clk;
  // strobe taken mid-cycle, where it has settled
  always @(negedge ref_clk)
    if (wr.valid === 1'b1)
      wq.push_back(wr);
  scp_serial_config_slave_port u_dut
  (
    .ref_clk(ref_clk), .resetn(resetn), .ce(ce), .sclIn(!sclPull), .sdaIn(sda),
    .sdaOut(sdaOut), .sdaOe(sdaOe), .addrStrapPin(strap), .second_port_addr_enable(pe),
    .portSel(portSel), .wrEvent(wr), .proxyRun(pRun), .proxySclIn(psc),
    .proxySclOut(pOut), .proxySclOe(pOe)
  );
  scp_host_model u_host (.clk(ref_clk), .sdaLine(sda), .sclPull(sclPull), .sdaPull(sdaPull));
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic check(input logic [19:0] seen, input logic [19:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic complete_run();
    if (errors == 0 && total_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic do_reset();
    resetn = 1'b0;
    repeat (8) @(negedge ref_clk);
    resetn = 1'b1;
    repeat (12) @(negedge ref_clk);
  endtask
  task automatic open_at(input logic [6:0] a, input logic rw);
    u_host.cond(1'b1);
    u_host.xfer({a, rw}, 1'b1, rd, ack);
  endtask
  // strap moved after capture must not move the address
  task automatic t_strap();
    for (int k = 0; k < 8; k++)
    begin
      strap = 3'(k);
      do_reset();
      strap = ~strap;
      open_at(7'h0c + 7'(2 * k), 1'b0);
      u_host.cond(1'b0);
      check(20'(ack), 20'h0);
      open_at(7'h1a - 7'(2 * k), 1'b0);
      u_host.cond(1'b0);
      check(20'(ack), 20'h1);
    end
  endtask
  task automatic t_write_read();
    strap = 3'h2;
    do_reset();
    wq.delete();
    open_at(7'h10, 1'b0);
    u_host.xfer(8'h03, 1'b1, rd, a1);
    u_host.xfer(8'ha5, 1'b1, rd, a2);
    u_host.xfer(8'h5a, 1'b1, rd, ack);
    u_host.cond(1'b0);
    check({17'h0, a1, a2, ack}, 20'h0);
    check(20'(wq.size()), 20'h2);
    check({4'h0, wq[0].offset, wq[0].data}, 20'h003a5);
    check({4'h0, wq[1].offset, wq[1].data}, 20'h0045a);
    open_at(7'h10, 1'b0);
    u_host.xfer(8'h03, 1'b1, rd, a1);
    open_at(7'h10, 1'b1);
    u_host.xfer(8'hff, 1'b0, rd, a1);
    u_host.xfer(8'hff, 1'b1, rd2, a2);
    u_host.cond(1'b0);
    check({4'h0, rd, rd2}, 20'h0a55a);
    // offset past the file: acked, dropped, reads back zero
    open_at(7'h10, 1'b0);
    u_host.xfer(8'h0b, 1'b1, rd, a1);
    u_host.xfer(8'h66, 1'b1, rd, a2);
    open_at(7'h10, 1'b0);
    u_host.xfer(8'h0b, 1'b1, rd, a1);
    open_at(7'h10, 1'b1);
    u_host.xfer(8'hff, 1'b1, rd, ack);
    u_host.cond(1'b0);
    check({11'h0, a2, rd}, 20'h0);
  endtask
  // own address from offset 0 bits 7:1, select bit set
  task automatic t_own_addr();
    open_at(7'h10, 1'b0);
    u_host.xfer(8'h00, 1'b1, rd, a1);
    u_host.xfer(8'h81, 1'b1, rd, a2);
    u_host.cond(1'b0);
    open_at(7'h40, 1'b0);
    u_host.cond(1'b0);
    check(20'(ack), 20'h0);
    // bytes after a stop with no start are ignored
    u_host.xfer(8'h80, 1'b1, rd, ack);
    check(20'(ack), 20'h1);
    u_host.cond(1'b0);
    open_at(7'h10, 1'b0);
    u_host.cond(1'b0);
    check(20'(ack), 20'h1);
  endtask
  task automatic t_second();
    pe = 1'b1;
    do_reset();
    open_at(7'h11, 1'b0);
    u_host.cond(1'b0);
    check({18'h0, ack, portSel}, 20'h1);
    open_at(7'h10, 1'b0);
    u_host.cond(1'b0);
    check({18'h0, ack, portSel}, 20'h0);
  endtask
  // frozen clock enable delays the strap capture
  task automatic t_enable();
    ce = 1'b0;
    strap = 3'h5;
    do_reset();
    strap = 3'h1;
    repeat (4) @(negedge ref_clk);
    ce = 1'b1;
    repeat (12) @(negedge ref_clk);
    open_at(7'h0e, 1'b0);
    u_host.cond(1'b0);
    check(20'(ack), 20'h0);
    open_at(7'h16, 1'b0);
    u_host.cond(1'b0);
    check(20'(ack), 20'h1);
  endtask
  // remote slave holds the proxy clock low well past a half period
  task automatic t_proxy();
    hold = 1'b1;
    repeat (60) @(negedge ref_clk);
    check(20'(pOe), 20'h0);
    // half period counted only once the line reads high
    hold = 1'b0;
    repeat (20) @(negedge ref_clk);
    check(20'(pOe), 20'h0);
    repeat (10) @(negedge ref_clk);
    check(20'(pOe), 20'h1);
    // stop only while released, so no half is cut short
    repeat (30) @(negedge ref_clk);
    pRun = 1'b0;
    repeat (40) @(negedge ref_clk);
    check(20'(pOe), 20'h0);
    pRun = 1'b1;
    repeat (20) @(negedge ref_clk);
    check(20'(pOe), 20'h0);
    repeat (10) @(negedge ref_clk);
    check(20'(pOe), 20'h1);
  endtask
  initial
  begin
    repeat (8) @(negedge ref_clk);
    check({pOe, sdaOe, portSel, wr}, 20'h0);
    do_reset();
    t_strap();
    t_write_read();
    t_own_addr();
    t_second();
    t_enable();
    t_proxy();
    complete_run();
  end
endmodule
bind scp_serial_config_slave_port scp_port_properties u_chk
(
  .ref_clk(ref_clk), .resetn(resetn), .sclIn(sclIn), .sdaOut(sdaOut), .sdaOe(sdaOe),
  .second_port_addr_enable(second_port_addr_enable), .portSel(portSel), .wrEvent(wrEvent),
  .proxySclIn(proxySclIn), .proxySclOut(proxySclOut), .proxySclOe(proxySclOe)
);
